//--- hw/ecr_array.v
// Nonvolatile byte array with erase, byte program and cycle counter
`timescale 1ns/1ps
`default_nettype none
`include "ecr_defines.vh"
module ecr_array (
  // Clock
  input  wire                    i_core_clk,
  // Write side
  input  wire                    i_erase,
  input  wire                    i_we,
  input  wire [`ECR_AW-1:0]      i_waddr,
  input  wire [7:0]              i_wdata,
  input  wire                    i_count_inc,
  // Read side
  input  wire [`ECR_AW-1:0]      i_raddr,
  output wire [7:0]              o_rdata,
  output wire [7:0]              o_count
);
  // Cells hold no reset: contents must survive a system reset
  reg [7:0] cell_ff [0:`ECR_DEPTH-1];
  reg [7:0] count_ff;
  integer   k;

  // Blank part at power-up
  initial begin
    for (k = 0; k < `ECR_DEPTH; k = k + 1) begin
      cell_ff[k] = `ECR_ERASED;
    end
    count_ff = 8'h00;
  end

  genvar g;
  generate
    for (g = 0; g < `ECR_DEPTH; g = g + 1) begin : g_cell
      always @(posedge i_core_clk) begin
        if (i_erase) begin
          cell_ff[g] <= `ECR_ERASED;
        end else if (i_we && (i_waddr == g)) begin
          cell_ff[g] <= i_wdata;
        end
      end
    end
  endgenerate

  always @(posedge i_core_clk) begin
    if (i_count_inc && (count_ff != `ECR_CNT_MAX)) begin
      count_ff <= count_ff + 8'h01;
    end
  end

  assign o_rdata = cell_ff[i_raddr];
  assign o_count = count_ff;
endmodule // ecr_array
`default_nettype wire

//--- hw/ecr_ctrl.v
// Store control, commit walks, erase/program timing and data readback
`timescale 1ns/1ps
`default_nettype none
`include "ecr_defines.vh"
module ecr_ctrl #(
  parameter [`ECR_TMR_W-1:0] P_CYCLE_CYC = `ECR_CYCLE_MS * `ECR_CLK_KHZ
) (
  // Clock and reset
  input  wire        i_core_clk,
  input  wire        i_sys_rst,
  // Serial register access from the bus engine
  input  wire        i_ptr_wr,
  input  wire [7:0]  i_ptr_val,
  input  wire        i_reg_wr,
  input  wire [7:0]  i_reg_wdata,
  input  wire        i_reg_rd,
  input  wire        i_xact_end,
  output wire [7:0]  o_reg_rdata,
  // Device register file port
  output wire [4:0]  o_cfg_addr,
  output wire        o_cfg_we,
  output wire [7:0]  o_cfg_wdata,
  input  wire [7:0]  i_cfg_rdata,
  // Status
  output wire        o_store_busy,
  output wire        o_load_active,
  output wire [7:0]  o_cycle_count
);
  localparam [2:0] ST_IDLE  = 3'h0;
  localparam [2:0] ST_LOAD  = 3'h1;
  localparam [2:0] ST_COPY  = 3'h2;
  localparam [2:0] ST_ERASE = 3'h3;
  localparam [2:0] ST_PROG  = 3'h4;
  localparam [2:0] ST_PWAIT = 3'h5;
  localparam [`ECR_TMR_W-1:0] L_TMR_END = P_CYCLE_CYC - 22'h1;

  function [7:0] crc8_step;
    input [7:0] crc;
    input [7:0] data;
    reg   [7:0] c;
    integer     b;
    begin
      c = crc ^ data;
      for (b = 0; b < 8; b = b + 1) begin
        c = c[7] ? ((c << 1) ^ `ECR_CRC_POLY) : (c << 1);
      end
      crc8_step = c;
    end
  endfunction

  reg [2:0]            st_ff;
  reg [`ECR_AW-1:0]    idx_ff;
  reg [7:0]            crc_ff;
  reg [`ECR_TMR_W-1:0] tmr_ff;
  reg                  both_ff;
  reg [7:0]            ptr_ff;
  reg                  lock_ff;
  reg [`ECR_AW-1:0]    iaddr_ff;
  reg [6:0]            madr_ff;
  reg                  auto_ff;
  reg                  crcerr_ff;
  reg                  key_seen_ff;
  reg                  armed_ff;
  reg [7:0]            rdata_ff;
  reg [7:0]            lcrc_ff;
  reg [4:0]            cfg_addr_ff;
  reg                  cfg_we_ff;
  reg [7:0]            cfg_wdata_ff;
  reg [7:0]            sram [0:`ECR_DEPTH-1];

  wire                 busy    = (st_ff == ST_ERASE) || (st_ff == ST_PROG) || (st_ff == ST_PWAIT);
  wire                 sel_dat = (ptr_ff == `ECR_A_DAT);
  wire                 dat_acc = sel_dat && (i_reg_rd || i_reg_wr);
  wire                 ctl_wr  = i_reg_wr && (ptr_ff == `ECR_A_CTL);
  wire                 tmr_end = (tmr_ff == L_TMR_END);
  wire                 last    = (idx_ff == `ECR_CRC_IDX);
  // Lower five bits only address the array
  wire [`ECR_AW-1:0]   rd_addr = lock_ff ? (iaddr_ff + 5'h1) : madr_ff[4:0];
  wire [`ECR_AW-1:0]   arr_raddr = (st_ff == ST_LOAD) ? idx_ff : rd_addr;
  wire [7:0]           arr_rdata;
  wire                 arr_we    = (st_ff == ST_PROG);
  // Checksum byte replaced by the computed value when enabled
  wire [7:0]           arr_wdata = (last && auto_ff) ? crc_ff : sram[idx_ff];
  wire                 erase_go  = ctl_wr && (st_ff == ST_IDLE) && armed_ff && i_reg_wdata[`ECR_B_ERASE];
  wire                 cnt_inc   = tmr_end && (((st_ff == ST_ERASE) && !both_ff) || (st_ff == ST_PWAIT));

  ecr_array u_array (
    .i_core_clk  (i_core_clk),
    .i_erase     (erase_go),
    .i_we        (arr_we),
    .i_waddr     (idx_ff),
    .i_wdata     (arr_wdata),
    .i_count_inc (cnt_inc),
    .i_raddr     (arr_raddr),
    .o_rdata     (arr_rdata),
    .o_count     (o_cycle_count)
  );

  // Commit, erase and program sequencer; starts with a load out of reset
  always @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      st_ff        <= ST_LOAD;
      idx_ff       <= 5'h00;
      crc_ff       <= 8'h00;
      tmr_ff       <= 22'h000000;
      both_ff      <= 1'b0;
      crcerr_ff    <= 1'b0;
      lcrc_ff      <= 8'h00;
      cfg_addr_ff  <= 5'h00;
      cfg_we_ff    <= 1'b0;
      cfg_wdata_ff <= 8'h00;
    end else begin
      cfg_we_ff <= 1'b0;
      case (st_ff)
        ST_IDLE: begin
          idx_ff      <= 5'h00;
          crc_ff      <= 8'h00;
          tmr_ff      <= 22'h000000;
          cfg_addr_ff <= 5'h00;
          // Commands are refused unless the sequencer is idle
          if (ctl_wr) begin
            if (armed_ff && i_reg_wdata[`ECR_B_ERASE]) begin
              both_ff <= i_reg_wdata[`ECR_B_PROG];
              st_ff   <= ST_ERASE;
            end else if (armed_ff && i_reg_wdata[`ECR_B_PROG]) begin
              both_ff <= 1'b0;
              st_ff   <= ST_PROG;
            end else if (i_reg_wdata[`ECR_B_LOAD]) begin
              st_ff <= ST_LOAD;
            end else if (i_reg_wdata[`ECR_B_COPY]) begin
              st_ff <= ST_COPY;
            end
          end
        end
        ST_LOAD: begin
          cfg_addr_ff  <= idx_ff;
          cfg_wdata_ff <= arr_rdata;
          cfg_we_ff    <= !last;
          idx_ff       <= idx_ff + 5'h1;
          if (last) begin
            crcerr_ff <= (arr_rdata != crc_ff);
            lcrc_ff   <= crc_ff;
            st_ff     <= ST_IDLE;
          end else begin
            crc_ff <= crc8_step(crc_ff, arr_rdata);
          end
        end
        ST_COPY: begin
          // The checksum slot has no register behind it
          cfg_addr_ff <= cfg_addr_ff + 5'h1;
          if (cfg_addr_ff == (`ECR_CRC_IDX - 5'h1)) begin
            st_ff <= ST_IDLE;
          end
        end
        ST_ERASE: begin
          tmr_ff <= tmr_ff + 22'h1;
          if (tmr_end) begin
            tmr_ff <= 22'h000000;
            st_ff  <= both_ff ? ST_PROG : ST_IDLE;
          end
        end
        ST_PROG: begin
          idx_ff <= idx_ff + 5'h1;
          if (last) begin
            lcrc_ff <= crc_ff;
            st_ff   <= ST_PWAIT;
          end else begin
            crc_ff <= crc8_step(crc_ff, sram[idx_ff]);
          end
        end
        ST_PWAIT: begin
          tmr_ff <= tmr_ff + 22'h1;
          if (tmr_end) begin
            both_ff <= 1'b0;
            st_ff   <= ST_IDLE;
          end
        end
        default: begin
          st_ff <= ST_IDLE;
        end
      endcase
    end
  end

  // Register image buffer; no reset, as the store array itself
  always @(posedge i_core_clk) begin
    if (st_ff == ST_COPY) begin
      sram[cfg_addr_ff] <= i_cfg_rdata;
    end
  end

  // Host-visible registers, pointer and unlock tracking
  always @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      ptr_ff      <= 8'h00;
      lock_ff     <= 1'b0;
      iaddr_ff    <= 5'h00;
      madr_ff     <= 7'h00;
      auto_ff     <= `ECR_AUTO_RST;
      key_seen_ff <= 1'b0;
      armed_ff    <= 1'b0;
      rdata_ff    <= 8'h00;
    end else begin
      if (i_ptr_wr) begin
        ptr_ff <= i_ptr_val;
      end else if ((i_reg_rd || i_reg_wr) && !sel_dat) begin
        ptr_ff <= ptr_ff + 8'h01;
      end

      if (i_reg_wr && (ptr_ff == `ECR_A_MADR)) begin
        madr_ff <= i_reg_wdata[6:0];
      end
      if (ctl_wr) begin
        auto_ff <= i_reg_wdata[`ECR_B_AUTO];
      end

      // Any register read or write after the key write spoils the unlock; pointer writes do not
      if (i_reg_wr && (ptr_ff == `ECR_A_KEY)) begin
        key_seen_ff <= (i_reg_wdata == `ECR_KEY_VAL);
      end else if (i_reg_rd || i_reg_wr) begin
        key_seen_ff <= 1'b0;
      end

      if (i_reg_rd) begin
        case (ptr_ff)
          `ECR_A_CTL:  rdata_ff <= {1'b0, (st_ff == ST_COPY), crcerr_ff, auto_ff,
                                    (st_ff == ST_LOAD), busy, 2'b00};
          `ECR_A_LCRC: rdata_ff <= lcrc_ff;
          `ECR_A_MADR: rdata_ff <= {1'b0, madr_ff};
          `ECR_A_DAT:  rdata_ff <= busy ? 8'h00 : arr_rdata;
          default:     rdata_ff <= 8'h00;
        endcase
      end

      if (dat_acc && (!lock_ff || (i_reg_rd && !busy))) begin
        iaddr_ff <= rd_addr;
      end
      if (dat_acc) begin
        lock_ff <= 1'b1;
      end

      if (i_xact_end) begin
        lock_ff     <= 1'b0;
        key_seen_ff <= 1'b0;
        // Key write in the same cycle as the end still counts
        armed_ff    <= (i_reg_wr && (ptr_ff == `ECR_A_KEY)) ?
                       (i_reg_wdata == `ECR_KEY_VAL) : key_seen_ff;
      end
    end
  end

  assign o_reg_rdata   = rdata_ff;
  assign o_cfg_addr    = cfg_addr_ff;
  assign o_cfg_we      = cfg_we_ff;
  assign o_cfg_wdata   = cfg_wdata_ff;
  assign o_store_busy  = busy;
  // Host must hold off register reads while this is high
  assign o_load_active = (st_ff == ST_LOAD);
endmodule // ecr_ctrl
`default_nettype wire

//--- hw/ecr_defines.vh
// Constants of the store control and readback block
`ifndef ECR_DEFINES_VH
`define ECR_DEFINES_VH

// Register pointer values
`define ECR_A_CTL      8'h31
`define ECR_A_LCRC     8'h32
`define ECR_A_MADR     8'h33
`define ECR_A_DAT      8'h34
`define ECR_A_KEY      8'h38
`define ECR_KEY_VAL    8'hbe

// Control field positions
`define ECR_B_COPY     6
`define ECR_B_AUTO     4
`define ECR_B_LOAD     3
`define ECR_B_ERASE    1
`define ECR_B_PROG     0
`define ECR_AUTO_RST   1'b1

// Store geometry: byte 31 holds the stored checksum
`define ECR_AW         5
`define ECR_DEPTH      32
`define ECR_CRC_IDX    5'h1f
`define ECR_ERASED     8'hff
`define ECR_CNT_MAX    8'hff
`define ECR_CRC_POLY   8'h07

// Timing
`define ECR_CYCLE_MS   115
`define ECR_CLK_KHZ    20000
`define ECR_TMR_W      22

`endif

//--- test/ecr_ctrl_monitor.sv
// Concurrent checks on the store control ports
`timescale 1ns/1ps
`default_nettype none
`include "ecr_defines.vh"
module ecr_ctrl_monitor #(
  parameter [`ECR_TMR_W-1:0] P_CYCLE_CYC = `ECR_CYCLE_MS * `ECR_CLK_KHZ
) (
  // Clock and reset
  input  wire logic       i_core_clk,
  input  wire logic       i_sys_rst,
  // Watched ports
  input  wire logic       i_reg_wr,
  input  wire logic       i_reg_rd,
  input  wire logic [7:0] o_reg_rdata,
  input  wire logic       o_cfg_we,
  input  wire logic       o_store_busy,
  input  wire logic       o_load_active,
  input  wire logic [7:0] o_cycle_count
);
  // Length of the current busy span, still valid at the edge where busy falls
  logic [`ECR_TMR_W:0] busy_len;
  always @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      busy_len <= '0;
    end else begin
      busy_len <= o_store_busy ? busy_len + 1'b1 : '0;
    end
  end
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_sys_rst);
  a_load_after_rst: assert property ($fell(i_sys_rst) |-> o_load_active [*8])
    else $error("load not running after reset");
  a_cfg_we_load: assert property (o_cfg_we |-> $past(o_load_active))
    else $error("register write outside load");
  a_busy_no_load: assert property (o_load_active |-> !o_store_busy)
    else $error("busy during load");
  a_busy_from_write: assert property ($rose(o_store_busy) |-> $past(i_reg_wr))
    else $error("busy without a write");
  a_busy_min_len: assert property ($fell(o_store_busy) |-> busy_len >= {1'b0, P_CYCLE_CYC})
    else $error("store cycle too short");
  a_busy_max_len: assert property (busy_len <= {P_CYCLE_CYC, 1'b0} + 40)
    else $error("store cycle too long");
  a_count_step: assert property ($changed(o_cycle_count) |-> o_cycle_count == $past(o_cycle_count) + 8'h01)
    else $error("count step wrong");
  a_count_sat: assert property (o_cycle_count == 8'hff |=> o_cycle_count == 8'hff)
    else $error("count left saturation");
  a_count_at_end: assert property ($changed(o_cycle_count) |-> $past(o_store_busy) || $past(o_store_busy, 2))
    else $error("count changed outside a cycle");
  a_rdata_holds: assert property (!$past(i_reg_rd) |-> $stable(o_reg_rdata))
    else $error("read data moved without read");
  cover property ($rose(o_store_busy));
  cover property ($fell(o_load_active));
  cover property (o_cycle_count == 8'h02);
endmodule // ecr_ctrl_monitor
bind ecr_ctrl ecr_ctrl_monitor #(.P_CYCLE_CYC(P_CYCLE_CYC)) u_mon (
  .i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
  .o_reg_rdata(o_reg_rdata), .o_cfg_we(o_cfg_we), .o_store_busy(o_store_busy),
  .o_load_active(o_load_active), .o_cycle_count(o_cycle_count));
`default_nettype wire

//--- test/ecr_regfile_model.sv
// Device register file model behind the load and copy port
`timescale 1ns/1ps
`default_nettype none
module ecr_regfile_model (
  // Clock
  input  wire logic       i_core_clk,
  // Register file port
  input  wire logic [4:0] i_addr,
  input  wire logic       i_we,
  input  wire logic [7:0] i_wdata,
  output var  logic [7:0] o_rdata
);
  logic [7:0] mem [0:31];
  assign o_rdata = mem[i_addr];
  always @(posedge i_core_clk) begin
    if (i_we === 1'b1) begin
      mem[i_addr] <= i_wdata;
    end
  end
endmodule // ecr_regfile_model
`default_nettype wire

//--- test/eeprom_control_and_readback_tb_top.sv
// Self-checking bench for the store control and readback block
`timescale 1ns/1ps
`default_nettype none
`include "ecr_defines.vh"
module eeprom_control_and_readback_tb_top;
  localparam [`ECR_TMR_W-1:0] P_CYC = 20;
  logic       i_core_clk, i_sys_rst, i_ptr_wr, i_reg_wr, i_reg_rd, i_xact_end, o_cfg_we, o_store_busy, o_load_active;
  logic [7:0] i_ptr_val, i_reg_wdata, o_reg_rdata, o_cfg_wdata, i_cfg_rdata, o_cycle_count, e0;
  logic [4:0] o_cfg_addr;
  integer     n_errors, check_count, n;
  ecr_ctrl #(.P_CYCLE_CYC(P_CYC)) u_dut (
    .i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst), .i_ptr_wr(i_ptr_wr), .i_ptr_val(i_ptr_val),
    .i_reg_wr(i_reg_wr), .i_reg_wdata(i_reg_wdata), .i_reg_rd(i_reg_rd), .i_xact_end(i_xact_end),
    .o_reg_rdata(o_reg_rdata), .o_cfg_addr(o_cfg_addr), .o_cfg_we(o_cfg_we), .o_cfg_wdata(o_cfg_wdata),
    .i_cfg_rdata(i_cfg_rdata), .o_store_busy(o_store_busy), .o_load_active(o_load_active),
    .o_cycle_count(o_cycle_count));
  ecr_regfile_model u_rf (.i_core_clk(i_core_clk), .i_addr(o_cfg_addr), .i_we(o_cfg_we),
    .i_wdata(o_cfg_wdata), .o_rdata(i_cfg_rdata));
  initial begin
    i_core_clk = 1'b0;
    forever #25 i_core_clk = ~i_core_clk;
  end
  function automatic logic [7:0] pat(input integer i);
    pat = 8'(i * 5 + 17);
  endfunction
  function automatic logic [7:0] crc8(input logic use_pat);
    logic [7:0] c;
    integer i, b;
    c = 8'h00;
    for (i = 0; i < 31; i++) begin
      c = c ^ (use_pat ? pat(i) : `ECR_ERASED);
      for (b = 0; b < 8; b++) c = c[7] ? {c[6:0], 1'b0} ^ `ECR_CRC_POLY : {c[6:0], 1'b0};
    end
    crc8 = c;
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    check_count = check_count + 1;
    if (got !== exp) begin
      n_errors = n_errors + 1;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  // Kind 0 pointer, 1 write, 2 read, 3 transaction end; one cycle each
  task automatic pulse(input integer k, input logic [7:0] v);
    @(posedge i_core_clk);
    #1;
    i_ptr_val = v;
    i_reg_wdata = v;
    case (k)
      0: i_ptr_wr = 1'b1;
      1: i_reg_wr = 1'b1;
      2: i_reg_rd = 1'b1;
      default: i_xact_end = 1'b1;
    endcase
    @(posedge i_core_clk);
    #1;
    {i_ptr_wr, i_reg_wr, i_reg_rd, i_xact_end} = 4'h0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    pulse(0, a);
    pulse(1, d);
    pulse(3, 8'h00);
  endtask
  task automatic rdn(input logic [7:0] exp, input string what);
    pulse(2, 8'h00);
    chk(o_reg_rdata, exp, what);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
    pulse(0, a);
    rdn(exp, what);
    pulse(3, 8'h00);
  endtask
  task automatic unlock;
    wr(`ECR_A_KEY, `ECR_KEY_VAL);
  endtask
  // Reads are held off until both the load and any store cycle are over
  task automatic wait_idle(input integer lim);
    integer i;
    for (i = 0; i < lim && (o_store_busy !== 1'b0 || o_load_active !== 1'b0); i++) @(posedge i_core_clk);
    #1;
    chk({6'h0, o_store_busy, o_load_active}, 8'h00, "idle");
  endtask
  task automatic t_reset;
    wait_idle(60);
    e0 = {2'b00, crc8(1'b0) !== `ECR_ERASED, 5'h10};
    rd(`ECR_A_LCRC, crc8(1'b0), "live checksum");
    rd(`ECR_A_MADR, 8'h00, "start address");
    rd(`ECR_A_CTL, e0, "status after reset");
    for (n = 0; n < 31; n++) u_rf.mem[n] = pat(n);
    $display("test reset done");
  endtask
  task automatic t_program;
    wr(`ECR_A_CTL, 8'h50);
    repeat (40) @(posedge i_core_clk);
    rd(`ECR_A_CTL, e0, "copy bit cleared");
    unlock;
    wr(`ECR_A_CTL, 8'h11);
    chk({7'h0, o_store_busy}, 8'h01, "busy on program");
    wait_idle(200);
    chk(o_cycle_count, 8'h01, "count after program");
    wr(`ECR_A_MADR, 8'h3e);
    pulse(0, `ECR_A_DAT);
    rdn(pat(30), "first stream byte");
    rdn(crc8(1'b1), "stored checksum byte");
    rdn(pat(0), "wrapped byte");
    pulse(3, 8'h00);
    rd(`ECR_A_MADR, 8'h3e, "start address kept");
    rd(`ECR_A_LCRC, crc8(1'b1), "live checksum");
    rd(`ECR_A_DAT, pat(30), "stream restarts");
    $display("test program done");
  endtask
  task automatic t_refuse;
    unlock;
    rd(`ECR_A_MADR, 8'h3e, "intervening read");
    wr(`ECR_A_CTL, 8'h12);
    chk({7'h0, o_store_busy}, 8'h00, "stale unlock");
    wr(`ECR_A_CTL, 8'h11);
    chk({7'h0, o_store_busy}, 8'h00, "no unlock");
    $display("test refuse done");
  endtask
  task automatic t_erase_prog;
    unlock;
    wr(`ECR_A_CTL, 8'h13);
    rd(`ECR_A_DAT, 8'h00, "read while busy");
    for (n = 0; n < 200 && o_store_busy === 1'b1; n++) @(posedge i_core_clk);
    chk(8'(n > 2 * P_CYC), 8'h01, "combined cycle length");
    wait_idle(10);
    chk(o_cycle_count, 8'h02, "count after combined");
    $display("test erase program done");
  endtask
  task automatic t_load;
    u_rf.mem[5] = 8'h00;
    wr(`ECR_A_CTL, 8'h18);
    wait_idle(60);
    chk(u_rf.mem[5], pat(5), "loaded register");
    rd(`ECR_A_CTL, 8'h10, "clean load status");
    $display("test load done");
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    n_errors = 0;
    check_count = 0;
    i_sys_rst = 1'b1;
    {i_ptr_wr, i_reg_wr, i_reg_rd, i_xact_end} = 4'h0;
    i_ptr_val = 8'h00;
    i_reg_wdata = 8'h00;
    repeat (8) @(posedge i_core_clk);
    #1;
    i_sys_rst = 1'b0;
    t_reset;
    t_program;
    t_refuse;
    t_erase_prog;
    t_load;
    finish_test;
  end
  // The sequence needs about 400 cycles; allow 20000
  initial begin
    #(50 * 20000);
    n_errors = n_errors + 1;
    $display("unexpected at %0t: watchdog expired", $time);
    finish_test;
  end
endmodule // eeprom_control_and_readback_tb_top
`default_nettype wire
